// [inc/dacl_pkg.sv]
/*
 * Constants for the sixteen-channel serial DAC loader: serial word layout,
 * mode codes, channel reset value, conversion timing and the APB map.
 * Assumes a 20 MHz pclk; every time below is turned into pclk cycles here.
 */
package dacl_pkg;

    // Serial word layout
    localparam int unsigned WORD_BITS   = 18;            // Bits in one command word
    localparam int unsigned MODE_HI     = 17;            // Mode field, top bit
    localparam int unsigned MODE_LO     = 16;            // Mode field, low bit
    localparam int unsigned ADDR_HI     = 15;            // Channel select, top bit
    localparam int unsigned ADDR_LO     = 12;            // Channel select, low bit
    localparam int unsigned CODE_HI     = 11;            // Code field, top bit
    localparam int unsigned STEP_HI     = 6;             // Step count, top bit
    localparam int unsigned CHAN_NUM    = 16;            // Channels in the device
    localparam int unsigned CODE_BITS   = 12;            // Width of a full code
    localparam int unsigned FRAC_BITS   = 2;             // Quarter-LSB bits
    localparam int unsigned VAL_BITS    = CODE_BITS + FRAC_BITS;

    // Mode field codes
    typedef enum logic [1:0] {
        DACL_MODE_LOAD = 2'h0,                            // Direct code load
        DACL_MODE_INC  = 2'h1,                            // Step up
        DACL_MODE_DEC  = 2'h2,                            // Step down
        DACL_MODE_NOP  = 2'h3                             // No operation
    } dacl_mode_e;

    // Channel value after reset: offset-binary zero, no fraction
    localparam logic [13:0] CHAN_RST    = 14'h2000;
    localparam logic [13:0] CHAN_MAX    = 14'h3fff;      // Saturation ceiling

    // Timing, in nanoseconds as printed, then in pclk cycles
    localparam int unsigned CLK_NS      = 50;            // pclk period
    localparam int unsigned LOAD_NS     = 25000;         // Typical load conversion
    localparam int unsigned STEP_NS     = 1000;          // Typical step update
    localparam int unsigned LOAD_CYC    = LOAD_NS / CLK_NS;
    localparam int unsigned STEP_CYC    = STEP_NS / CLK_NS;

    // APB register byte offsets
    localparam logic [7:0]  OFS_STATUS  = 8'h00;         // Block state, read only
    localparam logic [7:0]  OFS_CTRL    = 8'h04;         // Software control
    localparam logic [7:0]  OFS_WORD    = 8'h08;         // Last executed word
    localparam logic [7:0]  OFS_ABORTS  = 8'h0c;         // Aborted frame count
    localparam logic [7:0]  OFS_CHAN    = 8'h40;         // Channel 0 value, then +4
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000; // Control after reset

endpackage : dacl_pkg

// [logic/dacl_loader.sv]
/*
 * Serial command front end and update control of a sixteen-channel DAC.
 * Frame sync, serial clock, serial data, chain enable and power-down arrive
 * from pins and are sampled by pclk through two flip-flops each; the serial
 * clock is expected to be much slower than pclk (400 ns period in the bench).
 * Software reads channel values and status and sets control over APB.
 */
// Added by the designer: the address map and the APB slave port.
// How it works
// [R1] Commands are eighteen bits: mode, address, code
// [R2] Mode first, address high-to-low, then code bits
// [R3] Host sends most significant bit first
// [R4] Four address bits pick channel zero to fifteen
// [R5] Mode 00 loads code, starts long conversion
// [R6] Busy low during conversion; serial clocks ignored
// [R7] Host should not clock while busy low
// [R8] Modes 01/10 step channel by quarter LSB
// [R9] Step count is low seven code bits
// [R10] Step update finishes in about one microsecond
// [R11] Host spaces step writes 200/400 ns apart
// [R12] Mode 11 changes nothing at all; the word is still recorded in last_word
// [R13] Frame sync falling edge clears bit counter
// [R14] Frame sync edges ignored mid-word; the code ignores falls only, a rise in ST_SHIFT ends the frame
// [R15] Data sampled on serial clock falls, sync low
// [R16] Standalone: act on word at 18th fall
// [R17] Standalone: early sync rise aborts, no update
// [R18] Host toggles frame sync between transfers
// [R19] Standalone: clocks after 18th ignored until resync
// [R20] Chain: keep shifting, overflow goes to output
// [R21] Serial output changes on serial clock rises
// [R22] Host sends eighteen clocks per chained device
// [R23] Chain: act on held word at sync rise
// [R24] Chain enable low by default selects standalone
// [R25] Low reset returns everything to power-on state
// [R26] Channels start at reset value without commands
// [R27] Codes are offset binary, midscale is zero
// [R28] Power-down high puts all outputs high impedance
module dacl_loader #(
    parameter int unsigned LOAD_CYC = dacl_pkg::LOAD_CYC,  // Load conversion length
    parameter int unsigned STEP_CYC = dacl_pkg::STEP_CYC   // Step update length
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic           sync_n,
    input  wire logic           sclk,
    input  wire logic           din,
    input  wire logic           chain_enable,
    input  wire logic           power_down_in,
    output logic                dout,
    output logic                busy_n,
    output logic                out_hiz,
    output logic      [223:0]   chan_code
);

    // Counter must hold the longest conversion
    if (LOAD_CYC < 1 || LOAD_CYC > 1000 || STEP_CYC < 1 || STEP_CYC >= LOAD_CYC) begin : g_bad
        $error("dacl_loader: conversion cycle counts out of range");
    end

    // Frame handling states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,                  // Waiting for a frame sync fall
        ST_SHIFT = 4'h2,                  // Shifting bits in
        ST_WAIT  = 4'h4,                  // Word taken, waiting for sync to rise
        ST_CONV  = 4'h8                   // Conversion running, serial port deaf
    } dacl_state_e;

    // Whole module state
    typedef struct packed {
        dacl_state_e        state;        // Frame state
        logic [4:0]         bit_cnt;      // Bits shifted this frame, saturating
        logic [17:0]        sr;           // Input shift register
        logic               dout;         // Serial output
        logic               busy_n;       // Conversion in progress, low
        logic [9:0]         conv_cnt;     // Cycles left in conversion
        logic [15:0][13:0]  chan;         // Channel values, quarter-LSB units
        logic               hiz;          // Outputs in power-down
        logic [31:0]        ctrl;         // Software control
        logic [17:0]        last_word;    // Word most recently acted on
        logic [7:0]         aborts;       // Frames aborted, saturating
        logic               pready;       // APB answer
        logic               pslverr;      // APB error answer
        logic [31:0]        prdata;       // APB read data
        logic [2:0]         sync_p;       // Frame sync: meta, sync, previous
        logic [2:0]         sclk_p;       // Serial clock: meta, sync, previous
        logic [1:0]         din_p;        // Serial data: meta, sync
        logic [1:0]         ce_p;         // Chain enable: meta, sync
        logic [1:0]         pd_p;         // Power-down: meta, sync
    } dacl_state_s;

    dacl_state_s q;                       // Registered state
    dacl_state_s d;                       // Next state
    logic        sync_fall;               // Frame sync went low
    logic        sync_rise;               // Frame sync went high
    logic        sclk_fall;               // Serial clock fell
    logic        sclk_rise;               // Serial clock rose
    logic        exec;                    // Act on the shift register word
    logic        abort;                   // Drop the frame
    logic        exec_load;               // Executed word is a load
    logic [1:0]  w_mode;                  // Mode of the word being executed
    logic [3:0]  w_addr;                  // Channel of the word being executed
    logic [11:0] w_code;                  // Code of the word being executed
    logic [6:0]  w_step;                  // Step count of the word being executed
    logic [17:0] sr_next;                 // Shift register with the new bit
    logic [14:0] sum;                     // Step arithmetic with headroom
    logic        apb_acc;                 // Access phase awaiting answer
    logic        apb_wr;                  // Write commits this edge

    // Tells whether an address hits a channel register; low for a miss
    function automatic logic chan_hit(input logic [7:0] a);
        chan_hit = (a[7:6] == dacl_pkg::OFS_CHAN[7:6]) && (a[1:0] == 2'h0);
    endfunction : chan_hit

    // Edge detection works on the second and third stage only
    assign sync_fall = q.sync_p[2] & ~q.sync_p[1];
    assign sync_rise = ~q.sync_p[2] & q.sync_p[1];
    assign sclk_fall = q.sclk_p[2] & ~q.sclk_p[1];
    assign sclk_rise = ~q.sclk_p[2] & q.sclk_p[1];
    assign sr_next   = {q.sr[16:0], q.din_p[1]};                          // R2 R3

    // APB request phases
    assign apb_acc = psel & penable & ~q.pready;
    assign apb_wr  = psel & penable & q.pready & pwrite;

    // Next-state logic for the whole block
    always_comb begin
        d         = q;
        exec      = 1'b0;
        abort     = 1'b0;
        exec_load = 1'b0;
        w_mode    = q.sr[dacl_pkg::MODE_HI:dacl_pkg::MODE_LO];
        w_addr    = q.sr[dacl_pkg::ADDR_HI:dacl_pkg::ADDR_LO];
        w_code    = q.sr[dacl_pkg::CODE_HI:0];
        w_step    = q.sr[dacl_pkg::STEP_HI:0];
        sum       = 15'h0000;

        // Pin samplers
        d.sync_p  = {q.sync_p[1], q.sync_p[0], sync_n};
        d.sclk_p  = {q.sclk_p[1], q.sclk_p[0], sclk};
        d.din_p   = {q.din_p[0], din};
        d.ce_p    = {q.ce_p[0], chain_enable};
        d.pd_p    = {q.pd_p[0], power_down_in};

        // Power-down from pin or from software
        d.hiz     = q.pd_p[1] | q.ctrl[0];                               // R28

        // Frame state machine
        case (q.state)
            ST_IDLE: begin
                // A fresh sync fall starts a frame
                if (sync_fall) begin
                    d.bit_cnt = 5'h00;                                   // R13
                    d.state   = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (sync_rise) begin
                    if (q.ce_p[1] && q.bit_cnt >= 5'(dacl_pkg::WORD_BITS)) begin
                        exec    = 1'b1;                                  // R23
                        d.state = ST_IDLE;
                    end else begin
                        abort   = 1'b1;                                  // R17
                        d.state = ST_IDLE;
                    end
                end else if (sclk_fall) begin
                    // Only sync-low falls shift data in
                    d.sr = sr_next;                                      // R15
                    if (q.bit_cnt != 5'h1f) begin
                        d.bit_cnt = q.bit_cnt + 5'h01;
                    end
                    if (!q.ce_p[1] && q.bit_cnt == 5'(dacl_pkg::WORD_BITS - 1)) begin // R1
                        // Word complete in standalone use
                        w_mode  = sr_next[dacl_pkg::MODE_HI:dacl_pkg::MODE_LO];
                        w_addr  = sr_next[dacl_pkg::ADDR_HI:dacl_pkg::ADDR_LO];
                        w_code  = sr_next[dacl_pkg::CODE_HI:0];
                        w_step  = sr_next[dacl_pkg::STEP_HI:0];
                        exec    = 1'b1;                                  // R16
                        d.state = ST_WAIT;
                    end
                end else if (sclk_rise && q.ce_p[1]) begin
                    // Chained: the bit falling off the top goes out
                    d.dout = q.sr[dacl_pkg::WORD_BITS - 1];              // R20 R21
                end
            end
            ST_WAIT: begin
                // Extra clocks are ignored; only sync rise leaves
                if (sync_rise) begin
                    d.state = ST_IDLE;                                   // R19 R14
                end
            end
            ST_CONV: begin
                // Serial clocks and sync are ignored until done
                if (q.conv_cnt == 10'h001) begin
                    d.busy_n = 1'b1;                                     // R6
                    d.state  = ST_IDLE;
                end
                d.conv_cnt = q.conv_cnt - 10'h001;
            end
            default: begin
                d.state = ST_IDLE;
            end
        endcase

        // Acting on a word
        if (exec) begin
            d.last_word = {w_mode, w_addr, w_code};
            case (dacl_pkg::dacl_mode_e'(w_mode))
                dacl_pkg::DACL_MODE_LOAD: begin
                    // Offset-binary code, fraction cleared
                    exec_load         = 1'b1;
                    d.chan[w_addr]    = {w_code, 2'h0};                  // R4 R5 R27
                    d.conv_cnt        = 10'(LOAD_CYC);
                    d.busy_n          = 1'b0;                            // R6
                    d.state           = ST_CONV;
                end
                dacl_pkg::DACL_MODE_INC: begin
                    // Saturating quarter-LSB step up
                    sum = {1'b0, q.chan[w_addr]} + {8'h00, w_step};      // R8 R9
                    d.chan[w_addr] = sum[14] ? dacl_pkg::CHAN_MAX : sum[13:0];
                    d.conv_cnt     = 10'(STEP_CYC);                      // R10
                    d.busy_n       = 1'b0;
                    d.state        = ST_CONV;
                end
                dacl_pkg::DACL_MODE_DEC: begin
                    // Saturating quarter-LSB step down
                    sum = {1'b0, q.chan[w_addr]} - {8'h00, w_step};      // R8 R9
                    d.chan[w_addr] = sum[14] ? 14'h0000 : sum[13:0];
                    d.conv_cnt     = 10'(STEP_CYC);                      // R10
                    d.busy_n       = 1'b0;
                    d.state        = ST_CONV;
                end
                default: begin
                    // No operation: channels untouched
                    d.chan = q.chan;                                     // R12
                end
            endcase
        end

        // Count dropped frames
        if (abort && q.aborts != 8'hff) begin
            d.aborts = q.aborts + 8'h01;
        end

        // APB: answer one cycle into the access phase
        d.pready  = apb_acc;
        d.pslverr = 1'b0;
        if (apb_acc) begin
            d.prdata = 32'h0000_0000;
            if (paddr == dacl_pkg::OFS_STATUS) begin
                // Busy, frame active, chain mode, power-down
                d.prdata[3:0] = {q.hiz, q.ce_p[1], q.state == ST_SHIFT, ~q.busy_n};
            end else if (paddr == dacl_pkg::OFS_CTRL) begin
                d.prdata = q.ctrl;
            end else if (paddr == dacl_pkg::OFS_WORD) begin
                d.prdata[17:0] = q.last_word;
            end else if (paddr == dacl_pkg::OFS_ABORTS) begin
                d.prdata[7:0] = q.aborts;
            end else if (chan_hit(paddr)) begin
                d.prdata[13:0] = q.chan[paddr[5:2]];
            end else begin
                d.pslverr = 1'b1;
            end
        end
        if (apb_wr) begin
            if (paddr == dacl_pkg::OFS_CTRL) begin
                d.ctrl = {31'h0000_0000, pwdata[0]};
            end else if (paddr == dacl_pkg::OFS_STATUS || paddr == dacl_pkg::OFS_WORD ||
                         paddr == dacl_pkg::OFS_ABORTS || chan_hit(paddr)) begin
                // Read-only registers ignore writes
                d.ctrl = q.ctrl;
            end else begin
                d.ctrl = q.ctrl;
            end
        end
    end

    // State register; reset gives power-on values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.state     <= ST_IDLE;                                      // R25
            q.bit_cnt   <= 5'h00;
            q.sr        <= 18'h00000;
            q.dout      <= 1'b0;
            q.busy_n    <= 1'b1;
            q.conv_cnt  <= 10'h000;
            q.chan      <= {dacl_pkg::CHAN_NUM{dacl_pkg::CHAN_RST}};     // R26
            q.hiz       <= 1'b0;
            q.ctrl      <= dacl_pkg::CTRL_RST;
            q.last_word <= 18'h00000;
            q.aborts    <= 8'h00;
            q.pready    <= 1'b0;
            q.pslverr   <= 1'b0;
            q.prdata    <= 32'h0000_0000;
            q.sync_p    <= 3'h7;
            q.sclk_p    <= 3'h0;
            q.din_p     <= 2'h0;
            q.ce_p      <= 2'h0;                                         // R24
            q.pd_p      <= 2'h0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops
    assign prdata    = q.prdata;
    assign pready    = q.pready;
    assign pslverr   = q.pslverr;
    assign dout      = q.dout;
    assign busy_n    = q.busy_n;
    assign out_hiz   = q.hiz;
    assign chan_code = q.chan;

    // Assertion bounds
    localparam int A_LOAD    = LOAD_CYC;
    localparam int A_LOAD_HI = LOAD_CYC + 1;
    localparam int A_STEP    = STEP_CYC;
    localparam int A_STEP_HI = STEP_CYC + 1;

    a_load_busy_len: assert property (@(posedge pclk) disable iff (!presetn) // R5
        exec_load |=> !q.busy_n ##[A_LOAD:A_LOAD] q.busy_n)
        else $error("busy after load has wrong length");

    a_step_busy_len: assert property (@(posedge pclk) disable iff (!presetn) // R10
        (exec && !exec_load && w_mode != 2'h3) |-> ##[A_STEP:A_STEP_HI] q.busy_n)
        else $error("step update busy too long");

    a_busy_deaf: assert property (@(posedge pclk) disable iff (!presetn) // R6
        (!q.busy_n && !$past(exec)) |-> $stable(q.sr) && $stable(q.bit_cnt))
        else $error("serial port moved while busy");

    a_nop_still: assert property (@(posedge pclk) disable iff (!presetn) // R12
        (exec && w_mode == 2'h3) |=> $stable(q.chan) && q.busy_n)
        else $error("no-operation changed a channel");

    a_abort_still: assert property (@(posedge pclk) disable iff (!presetn) // R17
        abort |=> $stable(q.chan) && q.state == ST_IDLE && q.busy_n)
        else $error("aborted frame updated a channel");

    a_count_clear: assert property (@(posedge pclk) disable iff (!presetn) // R13
        (q.state == ST_IDLE && sync_fall) |=> q.bit_cnt == 5'h00 && q.state == ST_SHIFT)
        else $error("frame start did not clear bit counter");

    a_exec_at_18: assert property (@(posedge pclk) disable iff (!presetn) // R16
        (q.state == ST_SHIFT && !q.ce_p[1] && sclk_fall && !sync_rise &&
         q.bit_cnt == 5'h11) |-> exec)
        else $error("standalone word not acted on at 18th bit");

    a_load_value: assert property (@(posedge pclk) disable iff (!presetn) // R5 R4
        exec_load |=> q.chan[$past(w_addr)] == {$past(w_code), 2'h0})
        else $error("loaded channel value wrong");

    a_dout_rise: assert property (@(posedge pclk) disable iff (!presetn) // R21
        $changed(q.dout) |-> $past(sclk_rise) && $past(q.ce_p[1]))
        else $error("serial output changed off a rising clock");

    a_wait_deaf: assert property (@(posedge pclk) disable iff (!presetn) // R19
        (q.state == ST_WAIT && !sync_rise) |=> $stable(q.sr) && q.state == ST_WAIT)
        else $error("extra clocks shifted after word end");

    a_chain_exec: assert property (@(posedge pclk) disable iff (!presetn) // R23
        (q.state == ST_SHIFT && q.ce_p[1] && sync_rise && q.bit_cnt >= 5'h12) |-> exec)
        else $error("chained word not acted on at sync rise");

endmodule : dacl_loader

// [sim/dacl_host_model.sv]
/* Host serial port model: frame sync, serial clock and data toward the loader.
   Assumes the bench's pclk; the serial clock is 8 pclk (400 ns) and idles low. */
module dacl_host_model (
    input  wire logic        pclk,
    input  wire logic        busy_n,
    input  wire logic        dout,
    output logic             sync_n,
    output logic             sclk,
    output logic             din,
    output logic [35:0]      dout_cap
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle pins at time zero
    initial begin
        sync_n   = 1'b1;
        sclk     = 1'b0;
        din      = 1'b0;
        dout_cap = '0;
    end

    // Sends the low n bits of w, top bit first; may skip waiting for idle
    task automatic frame(input logic [35:0] w, input int n, input bit wait_idle);
        int i;
        int k;
        k = 0;
        while (wait_idle && busy_n !== 1'b1 && k < 2000) begin
            @(posedge pclk);
            k++;
        end
        // Busy never released: count it and close the run
        if (k >= 2000) begin
            dacl_loader_tb_top.n_mismatch++;
            dacl_loader_tb_top.print_verdict();
        end
        @(posedge pclk);
        sync_n <= 1'b0;
        repeat (4) @(posedge pclk);
        for (i = n - 1; i >= 0; i--) begin
            sclk <= 1'b1;
            din  <= w[i];
            repeat (4) @(posedge pclk);
            sclk <= 1'b0;
            repeat (4) @(posedge pclk);
            dout_cap <= {dout_cap[34:0], dout};
        end
        sync_n <= 1'b1;
        din    <= ~din;
        repeat (8) @(posedge pclk);
    endtask : frame
endmodule : dacl_host_model

// [sim/dacl_loader_tb_top.sv]
/* Self-checking bench: APB reads and serial frames with expected values.
   Assumes the loader package and the host model; long conversion shortened. */
module dacl_loader_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned LCYC = 200;   // Load conversion, outlasts one frame
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic         sync_n, sclk, din, dout, busy_n, out_hiz, chain_enable, power_down_in;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [35:0]  cap;
    logic [223:0] chan_code;
    int           n_mismatch, samples_checked;

    dacl_loader #(.LOAD_CYC(LCYC), .STEP_CYC(20)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_n(sync_n), .sclk(sclk),
        .din(din), .chain_enable(chain_enable), .power_down_in(power_down_in), .dout(dout),
        .busy_n(busy_n), .out_hiz(out_hiz), .chan_code(chan_code));
    dacl_host_model u_host (.pclk(pclk), .busy_n(busy_n), .dout(dout), .sync_n(sync_n),
        .sclk(sclk), .din(din), .dout_cap(cap));

    // Compares one value and counts it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints counts and the verdict, then stops
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // One APB transfer; request held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int t;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        rd   = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : apb

    // Reads a channel register and compares with code and quarter bits
    task automatic rchan(input int c, input logic [13:0] v);
        apb(1'b0, dacl_pkg::OFS_CHAN + 8'(4 * c), 32'h0);
        check(rd, {18'h0, v});
    endtask : rchan

    // Builds a command word: mode, channel, code
    function automatic logic [35:0] w(input logic [1:0] m, input logic [3:0] c,
                                      input logic [11:0] d);
        return {18'h0, m, c, d};
    endfunction : w

    // 50 ns clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Global limit on run time
    initial begin
        repeat (100000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, chain_enable, power_down_in} = '0;
        paddr = '0;
        pwdata = '0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rchan(15, 14'h2000);
        u_host.frame(w(2'h0, 4'h5, 12'habc), 18, 1'b1);
        check(busy_n, 0);
        u_host.frame(w(2'h1, 4'h5, 12'h001), 18, 1'b0);
        rchan(5, 14'h2af0);
        u_host.frame(w(2'h1, 4'h5, 12'hf7f), 18, 1'b1);
        rchan(5, 14'h2b6f);
        u_host.frame(w(2'h2, 4'h5, 12'h003), 18, 1'b1);
        rchan(5, 14'h2b6c);
        u_host.frame(w(2'h3, 4'h5, 12'h123), 18, 1'b1);
        rchan(5, 14'h2b6c);
        check(32'(chan_code[83:70]), 32'h0000_2b6c);
        apb(1'b0, dacl_pkg::OFS_WORD, 32'h0);
        check(rd, 32'h0003_5123);
        u_host.frame(w(2'h0, 4'hf, 12'h555) >> 8, 10, 1'b1);
        rchan(15, 14'h2000);
        apb(1'b0, dacl_pkg::OFS_ABORTS, 32'h0);
        check(rd, 32'h0000_0001);
        u_host.frame((w(2'h0, 4'h7, 12'h123) << 2) | 36'h3, 20, 1'b1);
        rchan(7, 14'h048c);
        chain_enable <= 1'b1;
        u_host.frame((w(2'h0, 4'h9, 12'h321) << 18) | w(2'h0, 4'h1, 12'hfff), 36, 1'b1);
        check(32'(cap[17:0]), 32'(w(2'h0, 4'h9, 12'h321)));
        rchan(1, 14'h3ffc);
        rchan(9, 14'h2000);
        chain_enable <= 1'b0;
        power_down_in <= 1'b1;
        repeat (5) @(posedge pclk);
        check(out_hiz, 1);
        power_down_in <= 1'b0;
        apb(1'b0, 8'h20, 32'h0);
        check(perr, 1);
        apb(1'b1, dacl_pkg::OFS_CTRL, 32'h1);
        repeat (3) @(posedge pclk);
        check(out_hiz, 1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rchan(5, 14'h2000);
        check(out_hiz, 0);
        apb(1'b0, dacl_pkg::OFS_ABORTS, 32'h0);
        check(rd, 32'h0000_0000);
        print_verdict();
    end
endmodule : dacl_loader_tb_top
